// >>> src/fse_fault_logic.sv
// Fault latches, seek error flip-flop and write interlock of the drive
// Operation
// [RULE1] Any set fault latch drives Fault
// [RULE2] Fault blocks writes, reports write protected
// [RULE3] Tag 3 bus bit 4 resets latches
// [RULE4] Reset clears only latches whose condition ended
// [RULE5] Processor code on lines 1-2 resets latches
// [RULE6] Power-up clears all fault state
// [RULE7] Voltage fault sets latch and drive disable
// [RULE8] Write inhibited during disable plus half second
// [RULE9] Voltage fault also sets seek error
// [RULE10] Gate while off cylinder sets latch
// [RULE11] Unsafe counts only when writing, no mark search
// [RULE12] Write fault or protect-with-gate sets latch
// [RULE13] Bad head faults only on write
// [RULE14] Read and write gates together set latch
// [RULE15] First-seek latch set by processor code
// [RULE16] Load errors raise first-seek fault
// [RULE17] Load aborted until panel clear pressed
// [RULE18] Low speed inhibits write and disables drive
// [RULE19] Cylinder above 822 sets seek error
// [RULE20] Processor code sets seek error
// [RULE21] Slow seek or settle dropouts flag seek error
// [RULE22] Three guard pulses flag seek error
// [RULE23] Seek error reports seek error and end
// [RULE24] Fault resets leave seek error; return to zero clears it
// [RULE25] Distinct single-cycle processor codes
// [RULE26] Master clear empties latches and seek error
//
// Added by the designer: the Wishbone interface to the registers and the address map.
`timescale 1ns/10ps
module fse_fault_logic #(
   parameter int HOLD_CYCLES = fse_pkg::HOLD_CYC, // Write inhibit tail
   parameter int RTZ_CYCLES = fse_pkg::RTZ_CYC, // Load return limit
   parameter int SEEK_CYCLES = fse_pkg::SEEK_CYC, // Normal seek limit
   parameter int BUS_W = fse_pkg::BUS_W_DEF // Tag bus width
) (
   input wire logic MCLK, // Clock
   input wire logic RESETN, // Power-up reset
   input wire logic WB_CYC_I, // Bus cycle
   input wire logic WB_STB_I, // Bus strobe
   input wire logic WB_WE_I, // Write
   input wire logic [3:0] WB_ADR_I, // Byte address
   input wire logic [3:0] WB_SEL_I, // Byte lanes
   input wire logic [31:0] WB_DAT_I, // Write data
   output logic [31:0] WB_DAT_O, // Read data
   output logic WB_ACK_O, // Acknowledge
   input wire logic TAG1, // Cylinder select tag
   input wire logic TAG2, // Head select tag
   input wire logic TAG3, // Control select tag
   input wire logic [BUS_W-1:0] BUS, // Tag bus
   input wire logic IOC1, // Processor control line 1
   input wire logic IOC2, // Processor control line 2
   input wire logic VOLT_FAULT_N, // Supply low
   input wire logic LOW_VCC_N, // Master clear request
   input wire logic SPEED_OK_N, // High when spindle slow
   input wire logic UNSAFE, // Preamp unsafe
   input wire logic ON_CYL, // On cylinder
   input wire logic ON_CYL_SENSE, // Servo on cylinder sense
   input wire logic PANEL_CLEAR, // Panel fault clear switch
   input wire logic LOAD_ACTIVE, // Load in progress
   input wire logic RTZ_PHASE, // Return to zero motion
   input wire logic SEEK_ACTIVE, // Seek in progress
   input wire logic SETTLE, // Settle-in window
   input wire logic GUARD_INNER, // Inner guard band pulse
   input wire logic GUARD_OUTER, // Outer guard band pulse
   output logic FAULT, // Fault line
   output logic WRITE_PROTECTED, // Write protected status
   output logic SEEK_ERROR, // Seek error status
   output logic SEEK_END, // Seek end status
   output logic WRITE_ENABLE_N, // Write enable, low active
   output logic DRIVE_DISABLE, // Servo input removed
   output logic READ_GATE, // Decoded read gate
   output logic WRITE_GATE, // Decoded write gate
   output logic MARK_SEARCH_ENABLE, // Decoded mark search
   output logic LOAD_ABORT, // Load locked out
   output logic [fse_pkg::N_LATCH-1:0] FAULT_LATCHES // Latch states
);
   import fse_pkg::*;

   function automatic logic rise(input logic now, input logic was);
      rise = now & ~was;
   endfunction : rise

   // ==========================================
   // Input synchronisers
   // VOLT_FAULT_N and LOW_VCC_N are inverted first so a reset of zero means idle
   localparam int NIN = 18 + BUS_W;
   logic [NIN-1:0] sync1;
   logic [NIN-1:0] sync2;
   logic [BUS_W-1:0] bus_s;
   logic tag1_s, tag2_s, tag3_s, ioc1_s, ioc2_s;
   logic volt_s, lowvcc_s, slow_s, unsafe_s, oncyl_s, sense_s, panel_s;
   logic load_s, rtzph_s, seek_s, settle_s, gi_s, go_s;

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {BUS, TAG1, TAG2, TAG3, IOC1, IOC2, ~VOLT_FAULT_N, ~LOW_VCC_N, SPEED_OK_N, UNSAFE,
                   ON_CYL, ON_CYL_SENSE, PANEL_CLEAR, LOAD_ACTIVE, RTZ_PHASE, SEEK_ACTIVE, SETTLE,
                   GUARD_INNER, GUARD_OUTER};
         sync2 <= sync1;
      end
   end

   assign {bus_s, tag1_s, tag2_s, tag3_s, ioc1_s, ioc2_s, volt_s, lowvcc_s, slow_s, unsafe_s,
           oncyl_s, sense_s, panel_s, load_s, rtzph_s, seek_s, settle_s, gi_s, go_s} = sync2;

   // Master clear for the fault state
   logic clr_all;
   assign clr_all = !RESETN || lowvcc_s; // [RULE6] [RULE26]

   // ==========================================
   // Previous samples for edge detection
   logic tag1_q, tag2_q, sense_q, panel_q, gi_q, go_q, volt_q, fc_q, rtz_q;
   logic fc_cmd, rtz_cmd;
   assign fc_cmd = tag3_s & bus_s[BIT_FAULT_CLEAR];
   assign rtz_cmd = tag3_s & bus_s[BIT_RTZ];

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         {tag1_q, tag2_q, sense_q, panel_q, gi_q, go_q, volt_q, fc_q, rtz_q} <= '0;
      end else begin
         {tag1_q, tag2_q, sense_q, panel_q} <= {tag1_s, tag2_s, sense_s, panel_s};
         {gi_q, go_q, volt_q, fc_q, rtz_q} <= {gi_s, go_s, volt_s, fc_cmd, rtz_cmd};
      end
   end

   logic fc_pulse, rtz_pulse, panel_pulse, volt_rise;
   assign fc_pulse = rise(fc_cmd, fc_q); // [RULE3]
   assign rtz_pulse = rise(rtz_cmd, rtz_q);
   assign panel_pulse = rise(panel_s, panel_q);
   assign volt_rise = rise(volt_s, volt_q);

   // ==========================================
   // Tag decode: gates follow tag 3, targets latch on tag 1 and 2
   logic rd_gate, wr_gate, mse, cyl_bad;
   logic [BUS_W-1:0] cyl_target;
   logic [HEAD_W-1:0] head;

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         rd_gate <= 1'b0;
         wr_gate <= 1'b0;
         mse <= 1'b0;
      end else begin
         rd_gate <= tag3_s & bus_s[BIT_READ_GATE];
         wr_gate <= tag3_s & bus_s[BIT_WRITE_GATE];
         mse <= tag3_s & bus_s[BIT_MARK_SEARCH];
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         cyl_target <= '0;
         head <= '0;
         cyl_bad <= 1'b0;
      end else begin
         cyl_bad <= rise(tag1_s, tag1_q) && (bus_s > BUS_W'(CYL_MAX)); // [RULE19]
         if (rise(tag1_s, tag1_q)) begin
            cyl_target <= bus_s;
         end
         if (rise(tag2_s, tag2_q)) begin
            head <= bus_s[HEAD_W-1:0];
         end
      end
   end

   // ==========================================
   // Processor code decoder
   // A code counts once the lines return to idle, so skew as the lines rise is harmless
   logic [1:0] ioc_code, ioc_held;
   logic ioc_reset, ioc_first, ioc_seek;
   assign ioc_code = {ioc2_s, ioc1_s};

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         ioc_held <= IOC_IDLE;
         ioc_reset <= 1'b0;
         ioc_first <= 1'b0;
         ioc_seek <= 1'b0;
      end else begin
         ioc_reset <= 1'b0;
         ioc_first <= 1'b0;
         ioc_seek <= 1'b0;
         if (ioc_code != IOC_IDLE) begin
            ioc_held <= ioc_code;
         end else begin
            ioc_held <= IOC_IDLE;
            case (ioc_held)
               IOC_FAULT_RESET: ioc_reset <= 1'b1; // [RULE5] [RULE25]
               IOC_FIRST_SEEK: ioc_first <= 1'b1; // [RULE15] [RULE25]
               IOC_SEEK_ERROR: ioc_seek <= 1'b1; // [RULE20] [RULE25]
               default: ioc_held <= IOC_IDLE;
            endcase
         end
      end
   end

   // ==========================================
   // Load and seek supervisor
   logic [TMR_W-1:0] tmr;
   logic [1:0] drops, guards;
   logic timing, rtz_late, seek_late, drops_hit, guard_hit;
   logic fs_cond, se_cond, se_q, abort, fw_first, fw_seek;
   logic fault;

   assign timing = (load_s & rtzph_s) | (seek_s & ~rtzph_s);
   assign rtz_late = load_s & rtzph_s & (tmr > TMR_W'(RTZ_CYCLES));
   assign seek_late = seek_s & ~rtzph_s & (tmr > TMR_W'(SEEK_CYCLES));
   assign drops_hit = drops >= DROP_LIMIT;
   assign guard_hit = guards >= GUARD_LIMIT;
   assign fs_cond = load_s & (rtz_late | drops_hit | slow_s | fault); // [RULE16]
   assign se_cond = seek_s & (seek_late | drops_hit | guard_hit); // [RULE21] [RULE22]
   assign fw_first = fs_cond & ~abort; // [RULE17]
   assign fw_seek = (se_cond & ~se_q) | volt_rise; // [RULE9]

   always_ff @(posedge MCLK) begin
      if (!RESETN || !timing) begin
         tmr <= '0;
      end else if (tmr != '1) begin
         tmr <= tmr + 1'b1;
      end
   end

   // Counters saturate so a long burst cannot wrap back below the limit
   always_ff @(posedge MCLK) begin
      if (!RESETN || !(load_s || seek_s)) begin
         drops <= '0;
      end else if (settle_s && rise(sense_q, sense_s) && !drops_hit) begin
         drops <= drops + 1'b1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESETN || !seek_s) begin
         guards <= '0;
      end else if (!guard_hit && (rise(gi_s, gi_q) || (!rtzph_s && rise(go_s, go_q)))) begin
         guards <= guards + 1'b1; // [RULE22]
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         abort <= 1'b0;
         se_q <= 1'b0;
      end else begin
         se_q <= se_cond;
         if (fs_cond) begin
            abort <= 1'b1; // [RULE17]
         end else if (panel_pulse) begin
            abort <= 1'b0;
         end
      end
   end

   // ==========================================
   // Seek error flip-flop
   logic seek_err, oncyl_eff;
   // Seek error makes the drive count as off cylinder until cleared
   assign oncyl_eff = oncyl_s & ~seek_err; // [RULE24]

   always_ff @(posedge MCLK) begin
      if (clr_all) begin
         seek_err <= 1'b0; // [RULE26]
      end else if (cyl_bad || ioc_seek || fw_seek) begin
         seek_err <= 1'b1; // [RULE19] [RULE20]
      end else if (rtz_pulse) begin
         seek_err <= 1'b0; // [RULE24]
      end
   end

   // ==========================================
   // Write interlock
   logic dis_ff, inhibit, wp_mode, wr_en, bad_head;
   logic [TMR_W-1:0] hold;
   assign inhibit = dis_ff | (hold != '0); // [RULE8]
   assign wr_en = wr_gate & ~fault & ~inhibit & ~wp_mode; // [RULE2] [RULE18]
   assign bad_head = head > HEAD_MAX;

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         dis_ff <= 1'b0;
         hold <= '0;
      end else begin
         dis_ff <= volt_s | slow_s; // [RULE7] [RULE18]
         if (dis_ff) begin
            hold <= TMR_W'(HOLD_CYCLES); // [RULE8]
         end else if (hold != '0) begin
            hold <= hold - 1'b1;
         end
      end
   end

   // ==========================================
   // Fault latches
   logic [N_LATCH-1:0] latch, cond, next_latch;
   logic fault_reset;

   always_comb begin
      fault_reset = fc_pulse | ioc_reset | panel_pulse; // [RULE3] [RULE5]
      cond = '0;
      cond[L_VOLT] = volt_s; // [RULE7]
      cond[L_OFFCYL] = ~oncyl_eff & (rd_gate | wr_gate); // [RULE10]
      cond[L_WRITE] = (unsafe_s & wr_en & ~mse) | (wp_mode & wr_gate) | (bad_head & wr_gate); // [RULE11] [RULE12] [RULE13]
      cond[L_RW] = rd_gate & wr_gate; // [RULE14]
      cond[L_FIRST] = ioc_first | fw_first; // [RULE15] [RULE16]
      // A live condition beats the reset, so only ended faults clear
      next_latch = cond | (latch & {N_LATCH{~fault_reset}}); // [RULE4]
   end

   always_ff @(posedge MCLK) begin
      if (clr_all) begin
         latch <= '0; // [RULE6] [RULE26]
         fault <= 1'b0;
      end else begin
         latch <= next_latch;
         fault <= |next_latch; // [RULE1]
      end
   end

   // ==========================================
   // Wishbone slave
   logic [31:0] next_dat;
   logic req;
   assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;

   always_comb begin
      next_dat = '0;
      case (WB_ADR_I)
         ADDR_CTRL: next_dat[CTRL_WP] = wp_mode;
         ADDR_STATUS: begin
            next_dat[N_LATCH-1:0] = latch;
            next_dat[ST_FAULT] = fault;
            next_dat[ST_SEEK_ERR] = seek_err;
            next_dat[ST_DISABLE] = dis_ff;
            next_dat[ST_INHIBIT] = inhibit;
            next_dat[ST_ABORT] = abort;
         end
         ADDR_TARGET: begin
            next_dat[BUS_W-1:0] = cyl_target;
            next_dat[TGT_HEAD +: HEAD_W] = head;
         end
         default: next_dat = '0;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= '0;
         wp_mode <= 1'b0;
      end else begin
         WB_ACK_O <= req;
         WB_DAT_O <= req ? next_dat : '0;
         if (req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == ADDR_CTRL) begin
            wp_mode <= WB_DAT_I[CTRL_WP];
         end
      end
   end

   // ==========================================
   // Status outputs
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         {FAULT, WRITE_PROTECTED, SEEK_ERROR, SEEK_END, DRIVE_DISABLE} <= '0;
         {READ_GATE, WRITE_GATE, MARK_SEARCH_ENABLE, LOAD_ABORT} <= '0;
         WRITE_ENABLE_N <= 1'b1;
         FAULT_LATCHES <= '0;
      end else begin
         FAULT <= fault; // [RULE1]
         WRITE_PROTECTED <= fault | wp_mode; // [RULE2]
         SEEK_ERROR <= seek_err; // [RULE23]
         SEEK_END <= seek_err; // [RULE23]
         DRIVE_DISABLE <= dis_ff; // [RULE18]
         WRITE_ENABLE_N <= ~wr_en; // [RULE8]
         READ_GATE <= rd_gate;
         WRITE_GATE <= wr_gate;
         MARK_SEARCH_ENABLE <= mse;
         LOAD_ABORT <= abort;
         FAULT_LATCHES <= latch;
      end
   end

endmodule : fse_fault_logic

// >>> src/fse_pkg.sv
// Shared constants for the drive fault and seek error logic
package fse_pkg;

   // ==========================================
   // Clock and timing
   localparam int CLK_KHZ = 100_000;
   localparam int HOLD_MS = 500;
   localparam int RTZ_LIMIT_MS = 1000;
   localparam int SEEK_LIMIT_MS = 65;
   localparam int HOLD_CYC = HOLD_MS * CLK_KHZ;
   localparam int RTZ_CYC = RTZ_LIMIT_MS * CLK_KHZ;
   localparam int SEEK_CYC = SEEK_LIMIT_MS * CLK_KHZ;
   localparam int TMR_W = 28;

   // ==========================================
   // Tag bus command bits
   localparam int BUS_W_DEF = 10;
   localparam int BIT_WRITE_GATE = 0;
   localparam int BIT_READ_GATE = 1;
   localparam int BIT_FAULT_CLEAR = 4;
   localparam int BIT_MARK_SEARCH = 5;
   localparam int BIT_RTZ = 6;
   localparam int HEAD_W = 4;
   localparam logic [9:0] CYL_MAX = 10'h336;
   localparam logic [3:0] HEAD_MAX = 4'h9;

   // ==========================================
   // Processor pulse codes on control lines 1 and 2
   localparam logic [1:0] IOC_IDLE = 2'h0;
   localparam logic [1:0] IOC_FAULT_RESET = 2'h1;
   localparam logic [1:0] IOC_FIRST_SEEK = 2'h2;
   localparam logic [1:0] IOC_SEEK_ERROR = 2'h3;

   // ==========================================
   // Fault latch indices and supervisor limits
   localparam int N_LATCH = 5;
   localparam int L_VOLT = 0;
   localparam int L_OFFCYL = 1;
   localparam int L_WRITE = 2;
   localparam int L_RW = 3;
   localparam int L_FIRST = 4;
   localparam logic [1:0] DROP_LIMIT = 2'h3;
   localparam logic [1:0] GUARD_LIMIT = 2'h3;

   // ==========================================
   // Register map and fields
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_TARGET = 4'h8;
   localparam int CTRL_WP = 0;
   localparam int ST_FAULT = 5;
   localparam int ST_SEEK_ERR = 6;
   localparam int ST_DISABLE = 7;
   localparam int ST_INHIBIT = 8;
   localparam int ST_ABORT = 9;
   localparam int TGT_HEAD = 16;

endpackage : fse_pkg

// >>> tb/fse_ctl_model.sv
// Disk controller model driving tags and tag bus
`timescale 1ns/10ps
module fse_ctl_model (
   input wire logic mclk, // Clock
   output logic tag1, // Cylinder select
   output logic tag2, // Head select
   output logic tag3, // Control select
   output logic [fse_pkg::BUS_W_DEF-1:0] bus // Tag bus
);
   import fse_pkg::*;
   initial begin
      tag1 = 1'h0;
      tag2 = 1'h0;
      tag3 = 1'h0;
      bus = '0;
   end
   // Bus settles a cycle ahead of the tag so capture never races it
   task automatic tag_on(input int t, input logic [BUS_W_DEF-1:0] v);
      @(posedge mclk);
      bus <= v;
      @(posedge mclk);
      tag1 <= (t == 1);
      tag2 <= (t == 2);
      tag3 <= (t == 3);
   endtask : tag_on
   // Deselected bus shows no stale value
   task automatic tag_off();
      @(posedge mclk);
      tag1 <= 1'h0;
      tag2 <= 1'h0;
      tag3 <= 1'h0;
      @(posedge mclk);
      bus <= ~bus;
   endtask : tag_off
   task automatic cmd(input int t, input logic [BUS_W_DEF-1:0] v, input int n);
      tag_on(t, v);
      repeat (n) @(posedge mclk);
      tag_off();
   endtask : cmd
endmodule : fse_ctl_model

// >>> tb/fse_fault_chk.sv
// Assertion checker for the drive fault logic pins
`timescale 1ns/10ps
module fse_fault_chk #(
   parameter int BUS_W = fse_pkg::BUS_W_DEF // Tag bus width
) (
   input wire logic MCLK, // Clock
   input wire logic RESETN, // Reset
   input wire logic TAG1, // Cylinder tag
   input wire logic TAG3, // Control tag
   input wire logic [BUS_W-1:0] BUS, // Tag bus
   input wire logic VOLT_FAULT_N, // Supply low
   input wire logic LOW_VCC_N, // Master clear
   input wire logic ON_CYL, // On cylinder
   input wire logic FAULT, // Fault line
   input wire logic WRITE_PROTECTED, // Protected status
   input wire logic SEEK_ERROR, // Seek error
   input wire logic SEEK_END, // Seek end
   input wire logic WRITE_ENABLE_N, // Write enable
   input wire logic DRIVE_DISABLE, // Drive disable
   input wire logic READ_GATE, // Read gate
   input wire logic WRITE_GATE, // Write gate
   input wire logic [fse_pkg::N_LATCH-1:0] FAULT_LATCHES // Latches
);
   import fse_pkg::*;
   logic [3:0] clr_age;

   // ==========================================
   // Age of the last clearing command; seek error may drop only soon after
   always_ff @(posedge MCLK) begin
      if (!RESETN) begin
         clr_age <= 4'hF;
      end else if ((TAG3 && BUS[BIT_RTZ]) || !LOW_VCC_N) begin
         clr_age <= 4'h0;
      end else if (clr_age != 4'hF) begin
         clr_age <= clr_age + 4'h1;
      end
   end

   // ==========================================
   // Properties
   default clocking dc @(posedge MCLK);
   endclocking
   default disable iff (!RESETN);

   fault_or_a: assert property (FAULT == (|FAULT_LATCHES))
      else $error("Fault line not the OR of the latches");
   fault_block_a: assert property ((FAULT && $past(FAULT)) |-> (WRITE_PROTECTED && WRITE_ENABLE_N))
      else $error("Write not blocked during fault");
   dis_wen_a: assert property ((DRIVE_DISABLE && $past(DRIVE_DISABLE)) |-> WRITE_ENABLE_N)
      else $error("Write enabled while drive disabled");
   tail_wen_a: assert property ($fell(DRIVE_DISABLE) |-> WRITE_ENABLE_N [*8])
      else $error("Write enabled too soon after disable");
   seek_end_a: assert property (SEEK_END == SEEK_ERROR)
      else $error("Seek end does not follow seek error");
   seek_drop_a: assert property ($fell(SEEK_ERROR) |-> (clr_age < 4'h8))
      else $error("Seek error dropped without a clearing command");
   rw_set_a: assert property ((READ_GATE && WRITE_GATE) |-> ##[1:4] FAULT_LATCHES[L_RW])
      else $error("Read and write together not latched");
   off_set_a: assert property ((!ON_CYL [*4] ##0 (READ_GATE || WRITE_GATE)) |-> ##[1:4] FAULT_LATCHES[L_OFFCYL])
      else $error("Gate off cylinder not latched");
   volt_set_a: assert property (!VOLT_FAULT_N [*3] |-> ##[0:4] (FAULT_LATCHES[L_VOLT] && DRIVE_DISABLE && SEEK_ERROR))
      else $error("Supply low did not latch, disable and flag seek error");
   cyl_err_a: assert property (($rose(TAG1) && (BUS > CYL_MAX)) |-> ##[1:6] SEEK_ERROR)
      else $error("Cylinder beyond range did not flag seek error");
endmodule : fse_fault_chk

bind fse_fault_logic fse_fault_chk #(.BUS_W(BUS_W)) u_chk (
   .MCLK(MCLK), .RESETN(RESETN), .TAG1(TAG1), .TAG3(TAG3), .BUS(BUS),
   .VOLT_FAULT_N(VOLT_FAULT_N), .LOW_VCC_N(LOW_VCC_N), .ON_CYL(ON_CYL),
   .FAULT(FAULT), .WRITE_PROTECTED(WRITE_PROTECTED), .SEEK_ERROR(SEEK_ERROR),
   .SEEK_END(SEEK_END), .WRITE_ENABLE_N(WRITE_ENABLE_N), .DRIVE_DISABLE(DRIVE_DISABLE),
   .READ_GATE(READ_GATE), .WRITE_GATE(WRITE_GATE), .FAULT_LATCHES(FAULT_LATCHES)
);

// >>> tb/fse_fault_logic_tb_top.sv
// Testbench for the drive fault and seek error logic
`timescale 1ns/10ps
module fse_fault_logic_tb_top;
   import fse_pkg::*;
   logic mclk, resetn, cyc, stb, we, ack, tag1, tag2, tag3, ioc1, ioc2, volt_n, lowvcc_n;
   logic speed_n, unsafe, on_cyl, panel, seek_act, g_in, g_out, load_a, rtz_ph, sense, settle;
   logic fault, wprot, serr, sek_end, wen_n, ddis, rgate, wgate, msen, labort;
   logic [3:0] adr, sel;
   logic [9:0] bus;
   logic [4:0] latches;
   logic [31:0] wdat, rdat, q;
   int bad_count, n_checks;

   fse_ctl_model ctl (.mclk(mclk), .tag1(tag1), .tag2(tag2), .tag3(tag3), .bus(bus));
   fse_fault_logic #(.HOLD_CYCLES(60), .RTZ_CYCLES(40), .SEEK_CYCLES(200)) uut (
      .MCLK(mclk), .RESETN(resetn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
      .TAG1(tag1), .TAG2(tag2), .TAG3(tag3), .BUS(bus), .IOC1(ioc1), .IOC2(ioc2),
      .VOLT_FAULT_N(volt_n), .LOW_VCC_N(lowvcc_n), .SPEED_OK_N(speed_n), .UNSAFE(unsafe),
      .ON_CYL(on_cyl), .ON_CYL_SENSE(sense), .PANEL_CLEAR(panel), .LOAD_ACTIVE(load_a),
      .RTZ_PHASE(rtz_ph), .SEEK_ACTIVE(seek_act), .SETTLE(settle), .GUARD_INNER(g_in),
      .GUARD_OUTER(g_out), .FAULT(fault), .WRITE_PROTECTED(wprot), .SEEK_ERROR(serr),
      .SEEK_END(sek_end), .WRITE_ENABLE_N(wen_n), .DRIVE_DISABLE(ddis), .READ_GATE(rgate),
      .WRITE_GATE(wgate), .MARK_SEARCH_ENABLE(msen), .LOAD_ABORT(labort), .FAULT_LATCHES(latches)
   );

   always #5 mclk = ~mclk;

   // ==========================================
   // Tasks
   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask : wt
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (ack !== 1'h1);
      chk("ack wait", 32'h2, k);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
   endtask : wb
   // Code is held, then lines return idle, which is when it acts
   task automatic ioc(input logic [1:0] c);
      @(posedge mclk);
      {ioc2, ioc1} <= c;
      wt(3);
      {ioc2, ioc1} <= IOC_IDLE;
      wt(6);
   endtask : ioc
   task automatic gpulse(input logic inner);
      @(posedge mclk);
      g_in <= inner;
      g_out <= !inner;
      wt(3);
      g_in <= 1'h0;
      g_out <= 1'h0;
      wt(3);
   endtask : gpulse
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict

   initial begin
      wt(5000);
      bad_count++;
      print_verdict();
   end

   // ==========================================
   // Scenarios
   initial begin
      {mclk, cyc, stb, we, ioc1, ioc2, speed_n, unsafe, panel, seek_act, g_in, g_out} = '0;
      {load_a, rtz_ph, sense, settle} = '0;
      {resetn, adr, sel, wdat} = '0;
      {volt_n, lowvcc_n, on_cyl} = 3'h7;
      bad_count = 0;
      n_checks = 0;
      wt(16);
      resetn <= 1'h1;
      wt(2);
      chk("wen_n", 1'h1, wen_n);
      chk("latches", 5'h00, latches);
      wb(1'h1, ADDR_CTRL, 32'h1);
      wb(1'h0, ADDR_CTRL, 32'h0);
      chk("ctrl", 32'h1, q);
      ctl.cmd(3, 10'h001, 8);
      wt(4);
      chk("protect gate", 5'h04, latches);
      wb(1'h0, ADDR_STATUS, 32'h0);
      chk("status", 32'h24, q & 32'hFF);
      wb(1'h1, ADDR_CTRL, 32'h0);
      wb(1'h0, 4'hC, 32'h0);
      chk("unmapped", 32'h0, q);
      ctl.cmd(3, 10'h010, 6);
      wt(4);
      chk("clear", 5'h00, latches);
      ctl.tag_on(3, 10'h003);
      wt(6);
      chk("rw latch", 5'h08, latches);
      chk("wprot", 1'h1, wprot);
      ctl.tag_on(3, 10'h013);
      wt(6);
      chk("held latch", 5'h08, latches);
      ctl.tag_off();
      ctl.cmd(3, 10'h010, 6);
      wt(4);
      chk("rw clear", 5'h00, latches);
      on_cyl <= 1'h0;
      ctl.cmd(3, 10'h002, 6);
      wt(2);
      chk("off cyl", 5'h02, latches);
      on_cyl <= 1'h1;
      wt(4);
      ioc(IOC_FAULT_RESET);
      chk("ioc reset", 5'h00, latches);
      ctl.cmd(2, 10'h00A, 6);
      wt(2);
      chk("bad head", 5'h00, latches);
      ctl.cmd(3, 10'h001, 6);
      wt(4);
      chk("bad head wr", 5'h04, latches);
      panel <= 1'h1;
      wt(4);
      panel <= 1'h0;
      wt(6);
      chk("panel", 5'h00, latches);
      ctl.cmd(2, 10'h000, 6);
      ioc(IOC_FIRST_SEEK);
      chk("first seek", 5'h10, latches);
      chk("no seek err", 1'h0, serr);
      ioc(IOC_SEEK_ERROR);
      chk("ioc seek", 1'h1, serr);
      chk("seek end", 1'h1, sek_end);
      ioc(IOC_FAULT_RESET);
      chk("reset only", 5'h00, latches);
      chk("serr kept", 1'h1, serr);
      ctl.cmd(3, 10'h040, 6);
      wt(4);
      chk("rtz", 1'h0, serr);
      ctl.cmd(1, 10'h336, 6);
      wt(4);
      chk("cyl 822", 1'h0, serr);
      wb(1'h0, ADDR_TARGET, 32'h0);
      chk("target", 32'h336, q & 32'h3FF);
      ctl.cmd(1, 10'h337, 6);
      wt(4);
      chk("cyl 823", 1'h1, serr);
      ctl.cmd(3, 10'h040, 6);
      volt_n <= 1'h0;
      wt(8);
      chk("volt", 5'h01, latches);
      chk("disable", 1'h1, ddis);
      chk("volt seek", 1'h1, serr);
      volt_n <= 1'h1;
      wt(6);
      ctl.cmd(3, 10'h010, 6);
      chk("volt serr", 1'h1, serr);
      ctl.cmd(3, 10'h040, 6);
      ctl.tag_on(3, 10'h001);
      wt(6);
      chk("hold", 1'h1, wen_n);
      wt(50);
      chk("wen", 1'h0, wen_n);
      speed_n <= 1'h1;
      wt(6);
      chk("slow dis", 1'h1, ddis);
      speed_n <= 1'h0;
      wt(10);
      chk("slow hold", 1'h1, wen_n);
      wt(70);
      ctl.tag_on(3, 10'h021);
      unsafe <= 1'h1;
      wt(6);
      chk("masked", 5'h00, latches);
      chk("mse", 1'h1, msen);
      ctl.tag_on(3, 10'h001);
      wt(6);
      chk("unsafe", 5'h04, latches);
      unsafe <= 1'h0;
      ctl.tag_off();
      ctl.cmd(3, 10'h010, 6);
      seek_act <= 1'h1;
      gpulse(1'h1);
      gpulse(1'h0);
      chk("two guards", 1'h0, serr);
      gpulse(1'h1);
      wt(2);
      chk("three guards", 1'h1, serr);
      seek_act <= 1'h0;
      ioc(IOC_FIRST_SEEK);
      lowvcc_n <= 1'h0;
      wt(4);
      lowvcc_n <= 1'h1;
      wt(6);
      chk("mclr latch", 5'h00, latches);
      chk("mclr serr", 1'h0, serr);
      seek_act <= 1'h1;
      settle <= 1'h1;
      repeat (3) begin
         sense <= 1'h1;
         wt(3);
         sense <= 1'h0;
         wt(3);
      end
      wt(3);
      chk("drops", 1'h1, serr);
      {seek_act, settle} <= 2'h0;
      wt(4);
      {load_a, rtz_ph} <= 2'h3;
      wt(50);
      chk("rtz slow", 5'h10, latches);
      chk("abort", 1'h1, labort);
      {load_a, rtz_ph} <= 2'h0;
      ctl.cmd(3, 10'h010, 6);
      wt(4);
      chk("fs clear", 5'h00, latches);
      chk("abort kept", 1'h1, labort);
      ioc(IOC_SEEK_ERROR);
      resetn <= 1'h0;
      wt(3);
      resetn <= 1'h1;
      wt(3);
      chk("reset serr", 1'h0, serr);
      print_verdict();
   end
endmodule : fse_fault_logic_tb_top
